/* hw/cmd_bus_ctl.sv */
// Processor card backplane controller: machine cycle sequencer, memory and I/O decode, DMA handoff.
// Assumes backplane pins arrive asynchronous to ref_clk and straps are static after reset.
// How it works
// - Memory counts selected only with request, read or write, and expansion all active.
// - Interrupt acknowledge raises its own strobe instead of memory request and read.
// - Wait request held active keeps the cycle in wait states.
// - Bus request releases all drivers except strapped expansion lines, waits, and grants with acknowledge.
// - On-card memory never answers while another master holds the bus.
// - Four 2K read-only sockets sit at the bottom 8K of the quadrant.
// - Four 1K RAM banks follow at 2000 to 2FFF; first bank fitted.
// - From 3000 up in the quadrant nothing on the card answers.
// - With on-card memory disabled all 64K go to external cards.
// - I/O cycles put the port number on both address bytes.
// - States after T3 are internal; pins hold, nothing new until T1.
// - Strap picks low quadrant, high quadrant from C000, or disabled.
// - Bank strap holds memory and I/O expansion lines low permanently.
`default_nettype none
module cmd_bus_ctl #(
  parameter int unsigned TSTATE_CYCLES = cmd_pkg::TSTATE_CYC,
  parameter logic [3:0] ROM_FITTED = cmd_pkg::ROM_FITTED_DEF,
  parameter logic [3:0] RAM_FITTED = cmd_pkg::RAM_FITTED_DEF
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire cmd_pkg::cmd_kind_e req_kind,
  input wire logic [cmd_pkg::ADDR_W-1:0] req_addr,
  input wire logic [cmd_pkg::DATA_W-1:0] req_wdata,
  input wire logic [cmd_pkg::XS_W-1:0] req_int_states,
  output logic done,
  output logic [cmd_pkg::DATA_W-1:0] rdata_q,
  output logic hole_q,
  output logic int_pending,
  input wire logic [1:0] map_strap,
  input wire logic bank_strap,
  input wire logic prog_en,
  input wire logic [cmd_pkg::ROM_AW+cmd_pkg::SOCK_W-1:0] prog_addr,
  input wire logic [cmd_pkg::DATA_W-1:0] prog_data,
  output logic [cmd_pkg::ADDR_W-1:0] bus_addr_q,
  output logic bus_addr_oe,
  input wire logic [cmd_pkg::DATA_W-1:0] bus_data_i,
  output logic [cmd_pkg::DATA_W-1:0] bus_data_o,
  output logic bus_data_oe,
  output logic memrq_n,
  output logic iorq_n,
  output logic rd_n,
  output logic wr_n,
  output logic intak_n,
  output logic ctl_oe,
  output logic memex_n,
  output logic memex_oe,
  output logic ioexp_n,
  output logic ioexp_oe,
  input wire logic waitrq_n,
  input wire logic busrq_n,
  input wire logic intrq_n,
  output logic busak_n
);
  import cmd_pkg::*;
  localparam int unsigned CNT_W = $clog2(TSTATE_CYCLES);

  // Refused at elaboration: a single-clock T-state leaves no room to restart the divider
  // Wait hold also relies on every T-state lasting two clocks or more
  if (TSTATE_CYCLES < 2) begin : g_bad_tstate
    $error("TSTATE_CYCLES must be at least 2");
  end

  cmd_state_e state_q;
  cmd_kind_e kind_q;
  cmd_map_e map_q;
  logic bank_q;
  logic [1:0] strap_cnt_q;
  logic [CNT_W-1:0] cnt_q;
  logic [XS_W-1:0] xs_q;
  logic [DATA_W-1:0] wdata_q;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic tick;
  logic accept;
  logic wait_act;
  logic busrq_act;
  logic [DATA_W-1:0] bus_data_s;
  logic [1:0] map_s;
  logic bank_s;
  logic strobe;
  logic is_mem;
  logic is_io;
  logic is_rd;
  logic is_wr;
  logic card_sel;
  logic card_drive;
  logic [DATA_W-1:0] card_rdata;
  logic rom_hit;
  logic ram_hit;
  logic hole_hit;
  logic [SOCK_W-1:0] rom_sock;
  logic [SOCK_W-1:0] ram_bank;

  // Every backplane input and strap goes through two flops before use
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= {3'b111, 3'b000, {DATA_W{1'b0}}};
      sync2_q <= {3'b111, 3'b000, {DATA_W{1'b0}}};
    end else begin
      sync1_q <= {waitrq_n, busrq_n, intrq_n, map_strap, bank_strap, bus_data_i};
      sync2_q <= sync1_q;
    end
  end
  assign wait_act = !sync2_q[SYNC_W-1];
  assign busrq_act = !sync2_q[SYNC_W-2];
  assign int_pending = !sync2_q[SYNC_W-3];
  assign map_s = sync2_q[SYNC_W-4 -: 2];
  assign bank_s = sync2_q[DATA_W];
  assign bus_data_s = sync2_q[DATA_W-1:0];

  // Straps are followed for a few cycles after release, then frozen
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_cnt_q <= '0;
      map_q <= MAP_LOW;
      bank_q <= 1'b0;
    end else if (strap_cnt_q != STRAP_SETTLE) begin
      strap_cnt_q <= strap_cnt_q + 2'b01;
      map_q <= cmd_map_e'(map_s);
      bank_q <= bank_s;
    end
  end

  assign req_ready = (state_q == ST_IDLE) && !busrq_act && (strap_cnt_q == STRAP_SETTLE);
  assign accept = req_valid && req_ready;

  // Time state divider restarts on a new cycle so T1 is a full state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (accept || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign tick = (cnt_q == CNT_W'(TSTATE_CYCLES - 1));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      xs_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (busrq_act) begin
            state_q <= ST_DMA;
          end else if (accept) begin
            state_q <= ST_T1;
            xs_q <= req_int_states;
          end
        end
        ST_T1: if (tick) begin
          state_q <= ST_T2;
        end
        ST_T2, ST_TW: if (tick) begin
          state_q <= wait_act ? ST_TW : ST_T3;
        end
        ST_T3: if (tick) begin
          state_q <= (xs_q != '0) ? ST_TX : ST_IDLE;
        end
        ST_TX: if (tick) begin
          xs_q <= xs_q - 1'b1;
          if (xs_q == XS_W'(1)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_DMA: if (!busrq_act) begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      kind_q <= KIND_MEM_RD;
      bus_addr_q <= '0;
      wdata_q <= '0;
    end else if (accept) begin
      kind_q <= req_kind;
      wdata_q <= req_wdata;
      if (req_kind == KIND_IO_RD || req_kind == KIND_IO_WR) begin
        bus_addr_q <= {req_addr[PORT_W-1:0], req_addr[PORT_W-1:0]};
      end else begin
        bus_addr_q <= req_addr;
      end
    end
  end

  assign is_mem = (kind_q == KIND_MEM_RD) || (kind_q == KIND_MEM_WR);
  assign is_io = (kind_q == KIND_IO_RD) || (kind_q == KIND_IO_WR);
  assign is_rd = (kind_q == KIND_MEM_RD) || (kind_q == KIND_IO_RD);
  assign is_wr = (kind_q == KIND_MEM_WR) || (kind_q == KIND_IO_WR);
  // Strobes fall at the start of T2 and rise at the end of T3; internal states leave them idle
  assign strobe = (state_q == ST_T2) || (state_q == ST_TW) || (state_q == ST_T3);

  assign memrq_n = !(strobe && is_mem);
  assign iorq_n = !(strobe && is_io);
  assign rd_n = !(strobe && is_rd);
  assign wr_n = !(strobe && is_wr);
  assign intak_n = !(strobe && (kind_q == KIND_INT_ACK));
  assign ctl_oe = (state_q != ST_DMA);
  assign bus_addr_oe = (state_q != ST_DMA);
  assign busak_n = (state_q != ST_DMA);
  // Strap is a hard tie to ground, so it stays driven even in DMA
  assign memex_n = !(bank_q || (strobe && is_mem));
  assign memex_oe = bank_q || (state_q != ST_DMA);
  assign ioexp_n = !(bank_q || (strobe && is_io));
  assign ioexp_oe = bank_q || (state_q != ST_DMA);

  cmd_decode u_decode (
    .addr(bus_addr_q),
    .map_sel(map_q),
    .rom_hit(rom_hit),
    .ram_hit(ram_hit),
    .hole_hit(hole_hit),
    .rom_sock(rom_sock),
    .ram_bank(ram_bank)
  );

  // Only this card's own cycles reach its memory; DMA traffic never does
  assign card_sel = strobe && !memrq_n && !(rd_n && wr_n) && !memex_n && (state_q != ST_DMA);

  cmd_card_mem #(
    .ROM_FITTED(ROM_FITTED),
    .RAM_FITTED(RAM_FITTED)
  ) u_card_mem (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sel(card_sel),
    .wr(is_wr),
    .rom_hit(rom_hit),
    .ram_hit(ram_hit),
    .rom_sock(rom_sock),
    .ram_bank(ram_bank),
    .offs(bus_addr_q[ROM_AW-1:0]),
    .wdata(wdata_q),
    .prog_en(prog_en),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .drive(card_drive),
    .rdata_q(card_rdata)
  );

  assign bus_data_oe = strobe && ((is_wr) || (card_sel && card_drive));
  assign bus_data_o = is_wr ? wdata_q : card_rdata;

  // Read data is taken at the close of T3; the vector on acknowledge comes from outside
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
      hole_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick && ((state_q == ST_T3 && xs_q == '0) || (state_q == ST_TX && xs_q == XS_W'(1)))) begin
        done <= 1'b1;
      end
      if (tick && state_q == ST_T3) begin
        rdata_q <= (card_sel && card_drive) ? card_rdata : bus_data_s;
        hole_q <= is_mem && hole_hit;
      end
    end
  end

  AST_DMA_RELEASE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_q == ST_DMA) |-> (!ctl_oe && !bus_addr_oe && !bus_data_oe && !busak_n))
    else $error("drivers not released during DMA");
  AST_NO_CARD_IN_DMA: assert property (@(posedge ref_clk) disable iff (!arst_n)
    busak_n == 1'b0 |-> !card_sel)
    else $error("card memory selected during DMA");
  AST_INTAK_NO_MEM: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !intak_n |-> (memrq_n && rd_n && !card_sel))
    else $error("memory enable during interrupt acknowledge");
  AST_IO_DUP: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !iorq_n |-> (bus_addr_q[15:8] == bus_addr_q[7:0]))
    else $error("port number not duplicated");
  AST_WAIT_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (tick && wait_act && (state_q == ST_T2 || state_q == ST_TW)) |=> (state_q == ST_TW) [*2])
    else $error("wait state not inserted");
  AST_SEL_COND: assert property (@(posedge ref_clk) disable iff (!arst_n)
    card_sel |-> (!memrq_n && !(rd_n && wr_n) && !memex_n))
    else $error("card selected without full qualification");
  AST_DRIVE_ONLY_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (bus_data_oe && !rd_n) |-> (!memrq_n && (rom_hit || ram_hit) && !hole_hit))
    else $error("card drove data outside a fitted socket");
  AST_TX_QUIET: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_q == ST_TX) |-> (memrq_n && iorq_n && rd_n && wr_n && $stable(bus_addr_q)))
    else $error("bus changed during internal state");
  AST_OFF_NO_HIT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (map_q == MAP_OFF) |-> (!rom_hit && !ram_hit && !hole_hit))
    else $error("disabled map still decodes");
  AST_BANK_TIE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    bank_q |-> (!memex_n && memex_oe && !ioexp_n && ioexp_oe))
    else $error("bank strap line not held low");
endmodule : cmd_bus_ctl
`default_nettype wire

/* hw/cmd_pkg.sv */
// Shared constants and types for the processor card memory and I/O decode block.
// Assumes a single 40 MHz reference clock; time states are derived from it.
`default_nettype none
package cmd_pkg;
  localparam int unsigned REF_CLK_NS = 25;
  localparam int unsigned TSTATE_NS = 400;
  localparam int unsigned TSTATE_CYC = (TSTATE_NS + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned XS_W = 3;
  localparam int unsigned ROM_AW = 11;
  localparam int unsigned RAM_AW = 10;
  localparam int unsigned SOCK_W = 2;
  localparam int unsigned SYNC_W = 6 + DATA_W;
  localparam logic [1:0] QUAD_LOW = 2'b00;
  localparam logic [1:0] QUAD_HIGH = 2'b11;
  localparam logic [13:0] RAM_BASE = 14'h2000;
  localparam logic [13:0] HOLE_BASE = 14'h3000;
  localparam logic [3:0] ROM_FITTED_DEF = 4'b1111;
  localparam logic [3:0] RAM_FITTED_DEF = 4'b0001;
  localparam logic [1:0] STRAP_SETTLE = 2'b11;
  typedef enum logic [2:0] {
    KIND_MEM_RD = 3'b000,
    KIND_MEM_WR = 3'b001,
    KIND_IO_RD = 3'b010,
    KIND_IO_WR = 3'b011,
    KIND_INT_ACK = 3'b100
  } cmd_kind_e;
  typedef enum logic [1:0] {
    MAP_LOW = 2'b00,
    MAP_HIGH = 2'b01,
    MAP_OFF = 2'b10,
    MAP_OFF_ALT = 2'b11
  } cmd_map_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_T1 = 3'b001,
    ST_T2 = 3'b010,
    ST_TW = 3'b011,
    ST_T3 = 3'b100,
    ST_TX = 3'b101,
    ST_DMA = 3'b110
  } cmd_state_e;
endpackage : cmd_pkg
`default_nettype wire

/* hw/cmd_decode.sv */
// Address decode of the on-card memory quadrant.
// Assumes the map strap is already settled; purely combinational.
`default_nettype none
module cmd_decode (
  input wire logic [cmd_pkg::ADDR_W-1:0] addr,
  input wire cmd_pkg::cmd_map_e map_sel,
  output logic rom_hit,
  output logic ram_hit,
  output logic hole_hit,
  output logic [cmd_pkg::SOCK_W-1:0] rom_sock,
  output logic [cmd_pkg::SOCK_W-1:0] ram_bank
);
  import cmd_pkg::*;
  logic quad_ok;
  logic [13:0] offs;
  always_comb begin
    unique case (map_sel)
      MAP_LOW: quad_ok = (addr[15:14] == QUAD_LOW);
      MAP_HIGH: quad_ok = (addr[15:14] == QUAD_HIGH);
      MAP_OFF, MAP_OFF_ALT: quad_ok = 1'b0;
    endcase
  end
  assign offs = addr[13:0];
  assign rom_hit = quad_ok && (offs < RAM_BASE);
  assign ram_hit = quad_ok && (offs >= RAM_BASE) && (offs < HOLE_BASE);
  assign hole_hit = quad_ok && (offs >= HOLE_BASE);
  assign rom_sock = offs[12:11];
  assign ram_bank = offs[11:10];
endmodule : cmd_decode
`default_nettype wire

/* hw/cmd_card_mem.sv */
// On-card read-only sockets and RAM banks.
// Assumes sel is only raised by the bus controller while a qualified memory access runs.
`default_nettype none
module cmd_card_mem #(
  parameter logic [3:0] ROM_FITTED = cmd_pkg::ROM_FITTED_DEF,
  parameter logic [3:0] RAM_FITTED = cmd_pkg::RAM_FITTED_DEF
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sel,
  input wire logic wr,
  input wire logic rom_hit,
  input wire logic ram_hit,
  input wire logic [cmd_pkg::SOCK_W-1:0] rom_sock,
  input wire logic [cmd_pkg::SOCK_W-1:0] ram_bank,
  input wire logic [cmd_pkg::ROM_AW-1:0] offs,
  input wire logic [cmd_pkg::DATA_W-1:0] wdata,
  input wire logic prog_en,
  input wire logic [cmd_pkg::ROM_AW+cmd_pkg::SOCK_W-1:0] prog_addr,
  input wire logic [cmd_pkg::DATA_W-1:0] prog_data,
  output logic drive,
  output logic [cmd_pkg::DATA_W-1:0] rdata_q
);
  import cmd_pkg::*;
  logic [DATA_W-1:0] rom_mem [0:(1 << (ROM_AW + SOCK_W)) - 1];
  logic [DATA_W-1:0] ram_mem [0:(1 << (RAM_AW + SOCK_W)) - 1];
  logic rom_ok;
  logic ram_ok;
  assign rom_ok = rom_hit && ROM_FITTED[rom_sock];
  assign ram_ok = ram_hit && RAM_FITTED[ram_bank];
  // Empty sockets stay off the bus so a card outside could answer instead
  assign drive = !wr && (rom_ok || ram_ok);
  // Sockets are only loaded by the programming port; bus writes never reach them
  always_ff @(posedge ref_clk) begin
    if (prog_en) begin
      rom_mem[prog_addr] <= prog_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sel && wr && ram_ok) begin
      ram_mem[{ram_bank, offs[RAM_AW-1:0]}] <= wdata;
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else if (sel && !wr) begin
      rdata_q <= rom_ok ? rom_mem[{rom_sock, offs}] : ram_mem[{ram_bank, offs[RAM_AW-1:0]}];
    end
  end
endmodule : cmd_card_mem
`default_nettype wire

/* testbench/cmd_ext_model.sv */
// Model of the far side: external memory and I/O cards, an interrupting card and an alternate bus master.
// Assumes the bench resolves the shared data bus and drives the model's command inputs.
`default_nettype none
module cmd_ext_model #(
  parameter logic [7:0] VEC = 8'he7
) (
  input wire logic ref_clk,
  input wire logic [15:0] bus_addr,
  input wire logic memrq_n,
  input wire logic iorq_n,
  input wire logic rd_n,
  input wire logic intak_n,
  input wire logic ioexp_n,
  input wire logic [1:0] card_map,
  input wire logic hold_wait,
  input wire logic dma_req,
  input wire logic int_req,
  output logic [7:0] ext_data,
  output logic waitrq_n,
  output logic busrq_n,
  output logic intrq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00;
  logic on_card;
  logic act;
  function automatic logic [7:0] ev(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : ev
  // External memory never sits in the card's quadrant while that quadrant is mapped in
  assign on_card = !card_map[1] && (bus_addr[15:14] == {2{card_map[0]}});
  assign act = !rd_n && ((!iorq_n && !ioexp_n) || (!memrq_n && !on_card));
  // An idle bus flips every cycle so a stale byte can never pass for a good read
  assign ext_data = !intak_n ? VEC : (act ? ev(bus_addr) : ~last_q);
  always_ff @(posedge ref_clk) begin
    last_q <= ext_data;
  end
  assign waitrq_n = !hold_wait;
  assign busrq_n = !dma_req;
  assign intrq_n = !int_req;
endmodule : cmd_ext_model
`default_nettype wire

/* testbench/cmd_bus_ctl_tb.sv */
// Self-checking bench for the card memory and I/O decode controller.
// Assumes cmd_pkg and cmd_ext_model are compiled first; T-state shortened to 4 clocks.
`default_nettype none
module cmd_bus_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cmd_pkg::*;
  localparam int unsigned TS = 4;
  localparam logic [7:0] VEC = 8'he7;
  typedef struct {
    cmd_kind_e k;
    logic [15:0] a;
    logic [7:0] w;
    logic [7:0] x;
    logic ck;
    logic h;
    logic dv;
    logic [2:0] xs;
  } cmd_row_s;
  logic ref_clk = 0, arst_n = 0, req_valid = 0, bank_strap = 0, prog_en = 0;
  logic hold_wait = 0, dma_req = 0, int_req = 0;
  cmd_kind_e req_kind = KIND_MEM_RD;
  logic [15:0] req_addr = 16'h0000;
  logic [15:0] bus_addr_q;
  logic [7:0] req_wdata = 8'h00, prog_data = 8'h00, rdata_q, bus_data_o, ext_data;
  logic [12:0] prog_addr = 13'h0000;
  logic [2:0] req_int_states = 3'h0;
  logic [1:0] map_strap = 2'b00;
  logic req_ready, done, hole_q, int_pending, bus_addr_oe, bus_data_oe, memrq_n, iorq_n, rd_n, wr_n;
  logic intak_n, ctl_oe, memex_n, memex_oe, ioexp_n, ioexp_oe, waitrq_n, busrq_n, intrq_n, busak_n;
  wire logic [7:0] bus_data_i = bus_data_oe ? bus_data_o : ext_data;
  int fail_count = 0, samples_checked = 0;
  cmd_row_s rows[13] = '{
    '{KIND_MEM_WR, 16'h2001, 8'ha5, 8'h00, 0, 0, 1, 3'h0}, '{KIND_MEM_RD, 16'h2001, 8'h00, 8'ha5, 1, 0, 1, 3'h0},
    '{KIND_MEM_RD, 16'h0005, 8'h00, 8'h11, 1, 0, 1, 3'h0}, '{KIND_MEM_RD, 16'h1fff, 8'h00, 8'h33, 1, 0, 1, 3'h0},
    '{KIND_MEM_WR, 16'h23ff, 8'h5a, 8'h00, 0, 0, 1, 3'h0}, '{KIND_MEM_RD, 16'h23ff, 8'h00, 8'h5a, 1, 0, 1, 3'h0},
    '{KIND_MEM_RD, 16'h3000, 8'h00, 8'h00, 0, 1, 0, 3'h0}, '{KIND_MEM_RD, 16'h4000, 8'h00, 8'h7c, 1, 0, 0, 3'h2},
    '{KIND_IO_RD, 16'h007e, 8'h00, 8'h3c, 1, 0, 0, 3'h0}, '{KIND_IO_WR, 16'h00ff, 8'h5c, 8'h00, 0, 0, 1, 3'h0},
    '{KIND_INT_ACK, 16'h0000, 8'h00, VEC, 1, 0, 0, 3'h0}, '{KIND_MEM_WR, 16'h0005, 8'h00, 8'h00, 0, 0, 1, 3'h0},
    '{KIND_MEM_RD, 16'h0005, 8'h00, 8'h11, 1, 0, 1, 3'h0}};
  cmd_bus_ctl #(.TSTATE_CYCLES(TS)) uut (
    .ref_clk, .arst_n, .req_valid, .req_ready, .req_kind, .req_addr, .req_wdata, .req_int_states, .done,
    .rdata_q, .hole_q, .int_pending, .map_strap, .bank_strap, .prog_en, .prog_addr, .prog_data, .bus_addr_q,
    .bus_addr_oe, .bus_data_i, .bus_data_o, .bus_data_oe, .memrq_n, .iorq_n, .rd_n, .wr_n, .intak_n, .ctl_oe,
    .memex_n, .memex_oe, .ioexp_n, .ioexp_oe, .waitrq_n, .busrq_n, .intrq_n, .busak_n);
  cmd_ext_model #(.VEC(VEC)) ext (.ref_clk, .bus_addr(bus_addr_q), .memrq_n, .iorq_n, .rd_n, .intak_n, .ioexp_n,
    .card_map(map_strap), .hold_wait, .dma_req, .int_req, .ext_data, .waitrq_n, .busrq_n, .intrq_n);
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic stall(input string msg);
    fail_count++;
    $display("mismatch at %0t: %s", $time, msg);
    print_verdict();
  endtask : stall
  task automatic rst(input logic [1:0] m, input logic b);
    @(negedge ref_clk);
    arst_n = 0;
    map_strap = m;
    bank_strap = b;
    repeat (10) @(negedge ref_clk);
    arst_n = 1;
  endtask : rst
  task automatic prog(input logic [12:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    prog_en = 1;
    prog_addr = a;
    prog_data = d;
    @(negedge ref_clk);
    prog_en = 0;
  endtask : prog
  // One machine cycle; n returns the clocks from acceptance to done
  task automatic run(input cmd_row_s r, output int n);
    logic m, i, k, d, mv, bad, rr, ww;
    logic [15:0] ea;
    logic [7:0] wv;
    logic [4:0] es;
    {m, i, k, d, mv, bad, rr, ww} = '0;
    wv = ~r.w;
    ea = (r.k == KIND_IO_RD || r.k == KIND_IO_WR) ? {2{r.a[7:0]}} : r.a;
    @(negedge ref_clk);
    req_valid = 1;
    req_kind = r.k;
    req_addr = r.a;
    req_wdata = r.w;
    req_int_states = r.xs;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 200) stall("request not taken");
    end
    @(negedge ref_clk);
    req_valid = 0;
    n = 1;
    while (done !== 1'b1) begin
      m |= !memrq_n;
      i |= !iorq_n && !ioexp_n;
      k |= !intak_n;
      d |= bus_data_oe;
      bad |= !memrq_n && (memex_n || (rd_n && wr_n));
      mv |= n > 1 && bus_addr_q !== ea;
      rr |= !rd_n;
      ww |= !wr_n;
      if (!wr_n) wv = bus_data_o;
      @(negedge ref_clk);
      n++;
      if (n > 1000) stall("cycle never finished");
    end
    if (r.ck) chk(16'(rdata_q), 16'(r.x), "read data");
    if (r.k == KIND_MEM_RD || r.k == KIND_MEM_WR) chk(16'(hole_q), 16'(r.h), "hole flag");
    es = {r.k < KIND_IO_RD, r.k[2:1] == 2'b01, r.k == KIND_INT_ACK, !r.k[0] && !r.k[2], r.k[0]};
    chk(16'({m, i, k, rr, ww}), 16'(es), "strobes");
    if (r.k[0]) chk(16'(wv), 16'(r.w), "write data");
    chk(16'({bad, mv}), 16'h0000, "select or address");
    chk(16'(d), 16'(r.dv), "card data drive");
  endtask : run
  initial begin
    cmd_row_s w;
    int n;
    int ns[13];
    rst(2'b00, 0);
    prog(13'h0005, 8'h11);
    prog(13'h1fff, 8'h33);
    int_req = 1;
    foreach (rows[j]) run(rows[j], ns[j]);
    chk(16'(int_pending), 16'h0001, "interrupt pending");
    int_req = 0;
    chk(16'(ns[7] - ns[2]), 16'(2 * TS), "internal states");
    // Slow card holds the cycle in wait states for forty clocks
    w = rows[7];
    w.xs = 3'h0;
    hold_wait = 1;
    fork
      run(w, n);
      begin
        repeat (40) @(negedge ref_clk);
        hold_wait = 0;
      end
    join
    chk(16'(n >= ns[2] + 6 * TS && n <= ns[2] + 40 + 2 * TS), 16'h0001, "wait stretch");
    dma_req = 1;
    n = 0;
    while (busak_n !== 1'b0) begin
      @(negedge ref_clk);
      n++;
      if (n > 30) stall("no bus grant");
    end
    repeat (5) begin
      @(negedge ref_clk);
      chk(16'({bus_addr_oe, ctl_oe, bus_data_oe, req_ready, memex_oe, ioexp_oe}), 16'h0000, "dma release");
    end
    dma_req = 0;
    repeat (8) @(negedge ref_clk);
    chk(16'({busak_n, ctl_oe}), 16'h0003, "dma return");
    rst(2'b01, 1);
    prog(13'h0005, 8'h11);
    run(cmd_row_s'{KIND_MEM_RD, 16'hc005, 8'h00, 8'h11, 1, 0, 1, 3'h0}, n);
    run(cmd_row_s'{KIND_MEM_RD, 16'h0005, 8'h00, 8'h39, 1, 0, 0, 3'h0}, n);
    chk(16'({memex_n, ioexp_n}), 16'h0000, "bank strap");
    rst(2'b10, 0);
    run(cmd_row_s'{KIND_MEM_RD, 16'h0005, 8'h00, 8'h39, 1, 0, 0, 3'h0}, n);
    run(cmd_row_s'{KIND_MEM_RD, 16'h3000, 8'h00, 8'h0c, 1, 0, 0, 3'h0}, n);
    chk(16'({memex_n, ioexp_n}), 16'h0003, "no bank strap");
    print_verdict();
  end
endmodule : cmd_bus_ctl_tb
`default_nettype wire
